// >>> timer_pair.sv
/*
 one pair of 16-bit timers, even and odd, run apart or joined into one
 32-bit timer, with its registers behind an AXI4-Lite slave.
 assumes all pins synchronous to mclk and a 32-bit AXI4-Lite master.
*/
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module timer_pair #(
   parameter bit FIRST_PAIR = 1'b1,
   parameter int ADDR_W     = 8
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // write address channel
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output logic                   awready,
   // write data channel
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // write response channel
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // read address channel
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output logic                   arready,
   // read data channel
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // device state and count sources
   input  wire logic              idleMode,
   input  wire logic              extGeneric,
   input  wire logic              lprcOsc,
   input  wire logic              secondaryOsc,
   input  wire logic              evenExtPin,
   input  wire logic              oddExtPin,
   input  wire logic              evenGate,
   input  wire logic              oddGate,
   // interrupt requests and trigger
   output logic                   evenIrq,
   output logic                   oddIrq,
   output logic [2:0]             evenPriority,
   output logic [2:0]             oddPriority,
   output logic                   adcTrigger
);
   import timer_pair_pkg::*;

   logic              awHeld_reg;
   logic              wHeld_reg;
   logic [ADDR_W-1:0] awAddr_reg;
   logic [31:0]       wData_reg;
   logic [3:0]        wStrb_reg;
   logic [15:0]       evenControl_reg;
   logic [15:0]       oddControl_reg;
   logic [15:0]       evenCount_reg;
   logic [15:0]       oddCount_reg;
   logic [15:0]       evenPeriod_reg;
   logic [15:0]       oddPeriod_reg;
   logic [15:0]       irqCtl_reg;
   logic [1:0]        flags_reg;
   logic [1:0]        flags_next;
   logic              doWrite;
   logic              wrEvenCtl;
   logic              wrOddCtl;
   logic              wrEvenCnt;
   logic              wrOddCnt;
   logic              wrEvenPer;
   logic              wrOddPer;
   logic              wrFlags;
   logic              wrIrq;
   logic              wide;
   logic [15:0]       oddUnitCtl;
   logic              evenTick;
   logic              oddTick;
   logic              evenGateFall;
   logic              oddGateFall;
   logic              matchEven;
   logic              matchOdd;
   logic              matchWide;
   logic [1:0]        flagSet;
   logic [1:0]        flagClr;
   logic [31:0]       readWord;

   // address lies on a mapped register
   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      logic [7:0] lo;
      lo = a[7:0];
      isMapped = (a == ADDR_W'(lo)) && (lo <= OFF_IRQ_CTRL) && (lo[1:0] == 2'h0);
   endfunction

   // byte-lane merge of a 16-bit register, unimplemented bits kept zero
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb,
                                           input logic [15:0] mask);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0] & mask[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8] & mask[15:8];
      end
      merge16 = res;
   endfunction

   // handshakes: accept each write channel once, read when idle
   assign awready = ~awHeld_reg;
   assign wready  = ~wHeld_reg;
   assign arready = ~rvalid;
   assign doWrite = awHeld_reg & wHeld_reg & ~bvalid;

   // write address and data holding, in either order
   always_ff @(posedge mclk) begin
      if (rst) begin
         awHeld_reg <= 1'b0;
         wHeld_reg  <= 1'b0;
         awAddr_reg <= '0;
         wData_reg  <= '0;
         wStrb_reg  <= '0;
      end else begin
         if (awvalid && !awHeld_reg) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= awaddr;
         end else if (doWrite) begin
            awHeld_reg <= 1'b0;
         end
         if (wvalid && !wHeld_reg) begin
            wHeld_reg <= 1'b1;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
         end else if (doWrite) begin
            wHeld_reg <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge mclk) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp  <= isMapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // write decode
   assign wrEvenCtl = doWrite & (awAddr_reg == ADDR_W'(OFF_EVEN_CTRL));
   assign wrOddCtl  = doWrite & (awAddr_reg == ADDR_W'(OFF_ODD_CTRL));
   assign wrEvenCnt = doWrite & (awAddr_reg == ADDR_W'(OFF_EVEN_CNT));
   assign wrOddCnt  = doWrite & (awAddr_reg == ADDR_W'(OFF_ODD_CNT));
   assign wrEvenPer = doWrite & (awAddr_reg == ADDR_W'(OFF_EVEN_PER));
   assign wrOddPer  = doWrite & (awAddr_reg == ADDR_W'(OFF_ODD_PER));
   assign wrFlags   = doWrite & (awAddr_reg == ADDR_W'(OFF_FLAGS));
   assign wrIrq     = doWrite & (awAddr_reg == ADDR_W'(OFF_IRQ_CTRL));

   // control, period and interrupt control registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         evenControl_reg <= CTRL_RESET;
         oddControl_reg  <= CTRL_RESET;
         evenPeriod_reg  <= PERIOD_RESET;
         oddPeriod_reg   <= PERIOD_RESET;
         irqCtl_reg      <= WORD_ZERO;
      end else begin
         if (wrEvenCtl) begin
            evenControl_reg <= merge16(evenControl_reg, wData_reg, wStrb_reg,
                                       EVEN_CTRL_MASK);
         end
         if (wrOddCtl) begin
            oddControl_reg <= merge16(oddControl_reg, wData_reg, wStrb_reg,
                                      ODD_CTRL_MASK);
         end
         if (wrEvenPer) begin
            evenPeriod_reg <= merge16(evenPeriod_reg, wData_reg, wStrb_reg, COUNT_MAX);
         end
         if (wrOddPer) begin
            oddPeriod_reg <= merge16(oddPeriod_reg, wData_reg, wStrb_reg, COUNT_MAX);
         end
         if (wrIrq) begin
            irqCtl_reg <= merge16(irqCtl_reg, wData_reg, wStrb_reg, IRQ_CTRL_MASK);
         end
      end
   end

   // wide mode bit of this pair's even control
   assign wide = evenControl_reg[CTRL_WIDE];
   // odd timer settings have no effect while joined
   assign oddUnitCtl = wide ? CTRL_RESET : oddControl_reg;

   // even timer tick source, also drives the joined counter
   timer_tick_gen evenGen (
      .mclk         (mclk),
      .rst          (rst),
      .ctl          (evenControl_reg),
      .psClear      (wrEvenCtl & evenControl_reg[CTRL_RUN]),
      .idleMode     (idleMode),
      .extGeneric   (extGeneric),
      .lprcOsc      (lprcOsc),
      .extPin       (evenExtPin),
      .secondaryOsc (secondaryOsc),
      .gateIn       (evenGate),
      .countTick    (evenTick),
      .gateFall     (evenGateFall)
   );

   // odd timer tick source, idle while joined
   timer_tick_gen oddGen (
      .mclk         (mclk),
      .rst          (rst),
      .ctl          (oddUnitCtl),
      .psClear      (wrOddCtl & oddControl_reg[CTRL_RUN]),
      .idleMode     (idleMode),
      .extGeneric   (extGeneric),
      .lprcOsc      (lprcOsc),
      .extPin       (oddExtPin),
      .secondaryOsc (secondaryOsc),
      .gateIn       (oddGate),
      .countTick    (oddTick),
      .gateFall     (oddGateFall)
   );

   // period comparisons
   assign matchEven = (evenCount_reg == evenPeriod_reg);
   assign matchOdd  = (oddCount_reg == oddPeriod_reg);
   assign matchWide = matchEven & matchOdd;

   // even count: own counter or low word of the joined counter
   always_ff @(posedge mclk) begin
      if (rst) begin
         evenCount_reg <= WORD_ZERO;
      end else if (wrEvenCnt) begin
         evenCount_reg <= merge16(evenCount_reg, wData_reg, wStrb_reg, COUNT_MAX);
      end else if (evenTick) begin
         if (wide ? matchWide : matchEven) begin
            evenCount_reg <= WORD_ZERO;
         end else begin
            evenCount_reg <= evenCount_reg + COUNT_ONE;
         end
      end
   end

   // odd count: own counter or high word taking the low word carry
   always_ff @(posedge mclk) begin
      if (rst) begin
         oddCount_reg <= WORD_ZERO;
      end else if (wrOddCnt) begin
         oddCount_reg <= merge16(oddCount_reg, wData_reg, wStrb_reg, COUNT_MAX);
      end else if (wide && evenTick) begin
         if (matchWide) begin
            oddCount_reg <= WORD_ZERO;
         end else if (evenCount_reg == COUNT_MAX) begin
            oddCount_reg <= oddCount_reg + COUNT_ONE;
         end
      end else if (!wide && oddTick) begin
         if (matchOdd) begin
            oddCount_reg <= WORD_ZERO;
         end else begin
            oddCount_reg <= oddCount_reg + COUNT_ONE;
         end
      end
   end

   // flag events; joined pair reports on the odd flag
   always_comb begin
      flagSet = 2'h0;
      flagClr = 2'h0;
      if (wide) begin
         flagSet[FLAG_ODD] = (evenTick & matchWide) | evenGateFall;
      end else begin
         flagSet[FLAG_EVEN] = (evenTick & matchEven) | evenGateFall;
         flagSet[FLAG_ODD]  = (oddTick & matchOdd) | oddGateFall;
      end
      if (wrFlags && wStrb_reg[0]) begin
         flagClr = wData_reg[FLAG_ODD:FLAG_EVEN];
      end
      flags_next = (flags_reg & ~flagClr) | flagSet; // set wins
   end

   // sticky flags and trigger
   always_ff @(posedge mclk) begin
      if (rst) begin
         flags_reg  <= 2'h0;
         adcTrigger <= 1'b0;
      end else begin
         flags_reg  <= flags_next;
         adcTrigger <= FIRST_PAIR & (wide ? (evenTick & matchWide)
                                          : (oddTick & matchOdd));
      end
   end

   // interrupt requests gated by their enables
   assign evenIrq      = flags_reg[FLAG_EVEN] & irqCtl_reg[FLAG_EVEN];
   assign oddIrq       = flags_reg[FLAG_ODD] & irqCtl_reg[FLAG_ODD];
   assign evenPriority = irqCtl_reg[PRIO_EVEN_L +: PRIO_W];
   assign oddPriority  = irqCtl_reg[PRIO_ODD_L +: PRIO_W];

   // read mux
   always_comb begin
      readWord = 32'h0000_0000;
      unique case (araddr[7:0])
         OFF_EVEN_CTRL: readWord[15:0] = evenControl_reg;
         OFF_ODD_CTRL:  readWord[15:0] = oddControl_reg;
         OFF_EVEN_CNT:  readWord[15:0] = evenCount_reg;
         OFF_ODD_CNT:   readWord[15:0] = oddCount_reg;
         OFF_EVEN_PER:  readWord[15:0] = evenPeriod_reg;
         OFF_ODD_PER:   readWord[15:0] = oddPeriod_reg;
         OFF_FLAGS:     readWord[1:0]  = flags_reg;
         OFF_IRQ_CTRL:  readWord[15:0] = irqCtl_reg;
         default:       readWord = 32'h0000_0000;
      endcase
      if (!isMapped(araddr)) begin
         readWord = 32'h0000_0000;
      end
   end

   // read response
   always_ff @(posedge mclk) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= RESP_OKAY;
      end else if (arvalid && !rvalid) begin
         rvalid <= 1'b1;
         rdata  <= readWord;
         rresp  <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule

// >>> timer_pair_pkg.sv
/*
 constants shared by the paired 16/32-bit timer: control fields,
 register offsets, masks, prescale and source encodings, bus answers.
 assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package timer_pair_pkg;
   // control register fields
   localparam int CTRL_RUN    = 15;
   localparam int CTRL_IDLE   = 13;
   localparam int CTRL_ESRC_H = 9;
   localparam int CTRL_ESRC_L = 8;
   localparam int CTRL_GATE   = 6;
   localparam int CTRL_PS_H   = 5;
   localparam int CTRL_PS_L   = 4;
   localparam int CTRL_WIDE   = 3;
   localparam int CTRL_CS     = 1;
   // implemented bits of each control register
   localparam logic [15:0] EVEN_CTRL_MASK = 16'hA37A;
   localparam logic [15:0] ODD_CTRL_MASK  = 16'hA372;
   localparam logic [15:0] CTRL_RESET     = 16'h0000;
   localparam logic [15:0] WORD_ZERO      = 16'h0000;
   localparam logic [15:0] COUNT_ONE      = 16'h0001;
   localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
   localparam logic [15:0] PERIOD_RESET   = 16'hFFFF;
   // register byte offsets
   localparam logic [7:0] OFF_EVEN_CTRL = 8'h00;
   localparam logic [7:0] OFF_ODD_CTRL  = 8'h04;
   localparam logic [7:0] OFF_EVEN_CNT  = 8'h08;
   localparam logic [7:0] OFF_ODD_CNT   = 8'h0C;
   localparam logic [7:0] OFF_EVEN_PER  = 8'h10;
   localparam logic [7:0] OFF_ODD_PER   = 8'h14;
   localparam logic [7:0] OFF_FLAGS     = 8'h18;
   localparam logic [7:0] OFF_IRQ_CTRL  = 8'h1C;
   // flag and interrupt control fields
   localparam int FLAG_EVEN   = 0;
   localparam int FLAG_ODD    = 1;
   localparam int PRIO_EVEN_L = 4;
   localparam int PRIO_ODD_L  = 8;
   localparam int PRIO_W      = 3;
   localparam logic [15:0] IRQ_CTRL_MASK = 16'h0773;
   // extended source codes
   localparam logic [1:0] ESRC_GENERIC = 2'h3;
   localparam logic [1:0] ESRC_LOW_POWER_RC_OSCILLATOR    = 2'h2;
   localparam logic [1:0] ESRC_PIN     = 2'h1;
   localparam logic [1:0] ESRC_SECONDARY_OSCILLATOR    = 2'h0;
   // prescale codes and last count of each divider
   localparam logic [1:0] PS_256 = 2'h3;
   localparam logic [1:0] PS_64  = 2'h2;
   localparam logic [1:0] PS_8   = 2'h1;
   localparam logic [1:0] PS_1   = 2'h0;
   localparam logic [7:0] PS_LAST_256 = 8'hFF;
   localparam logic [7:0] PS_LAST_64  = 8'h3F;
   localparam logic [7:0] PS_LAST_8   = 8'h07;
   localparam logic [7:0] PS_LAST_1   = 8'h00;
   localparam logic [7:0] PS_STEP     = 8'h01;
   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> timer_tick_gen.sv
/*
 count tick source of one 16-bit timer: clock source select, gating,
 idle stop and prescaler; emits one-cycle count ticks and gate falls.
 assumes every source and gate input is synchronous to mclk.
*/
`timescale 1ns/1ps
module timer_tick_gen (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // settings
   input  wire logic [15:0] ctl,
   input  wire logic        psClear,
   input  wire logic        idleMode,
   // count sources and gate
   input  wire logic        extGeneric,
   input  wire logic        lprcOsc,
   input  wire logic        extPin,
   input  wire logic        secondaryOsc,
   input  wire logic        gateIn,
   // events
   output logic             countTick,
   output logic             gateFall
);
   import timer_pair_pkg::*;

   logic       half_reg;
   logic       srcPrev_reg;
   logic       gatePrev_reg;
   logic [7:0] psCount_reg;
   logic       srcLevel;
   logic       active;
   logic       internalSel;
   logic       gating;
   logic       rawTick;
   logic [7:0] psLast;

   // last prescaler count for a prescale code
   function automatic logic [7:0] psLastOf(input logic [1:0] code);
      unique case (code)
         PS_256:  psLastOf = PS_LAST_256;
         PS_64:   psLastOf = PS_LAST_64;
         PS_8:    psLastOf = PS_LAST_8;
         PS_1:    psLastOf = PS_LAST_1;
      endcase
   endfunction

   // external source select
   always_comb begin
      unique case (ctl[CTRL_ESRC_H:CTRL_ESRC_L])
         ESRC_GENERIC: srcLevel = extGeneric;
         ESRC_LOW_POWER_RC_OSCILLATOR:    srcLevel = lprcOsc;
         ESRC_PIN:     srcLevel = extPin;
         ESRC_SECONDARY_OSCILLATOR:    srcLevel = secondaryOsc;
      endcase
   end

   // run, idle stop, source and gate qualification
   assign active      = ctl[CTRL_RUN] & ~(idleMode & ctl[CTRL_IDLE]);
   assign internalSel = ~ctl[CTRL_CS];
   assign gating      = internalSel & ctl[CTRL_GATE];
   // all edges are taken in mclk, no asynchronous path
   assign rawTick = active & (internalSel ? half_reg : (srcLevel & ~srcPrev_reg))
                  & (~gating | gateIn);
   assign psLast  = psLastOf(ctl[CTRL_PS_H:CTRL_PS_L]);

   // half-rate internal clock and edge history
   always_ff @(posedge mclk) begin
      if (rst) begin
         half_reg     <= 1'b0;
         srcPrev_reg  <= 1'b0;
         gatePrev_reg <= 1'b0;
      end else begin
         half_reg     <= ~half_reg;
         srcPrev_reg  <= srcLevel;
         gatePrev_reg <= gateIn;
      end
   end

   // prescale counter, cleared by a control write while running
   always_ff @(posedge mclk) begin
      if (rst || psClear || !ctl[CTRL_RUN]) begin
         psCount_reg <= PS_LAST_1;
      end else if (rawTick) begin
         if (psCount_reg == psLast) begin
            psCount_reg <= PS_LAST_1;
         end else begin
            psCount_reg <= psCount_reg + PS_STEP;
         end
      end
   end

   // registered tick and gate falling event
   always_ff @(posedge mclk) begin
      if (rst) begin
         countTick <= 1'b0;
         gateFall  <= 1'b0;
      end else begin
         countTick <= rawTick & (psCount_reg == psLast) & ~psClear;
         gateFall  <= gating & active & gatePrev_reg & ~gateIn;
      end
   end
endmodule

// >>> timer_pair_props.sv
/*
 checker for the timer pair: bus answers, read-back of the even control
 register and the trigger pulse. sees only the top ports; bound below.
*/
`timescale 1ns/1ps
module timer_pair_props #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic              mclk,
   input wire logic              rst,
   // bus
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic              arvalid,
   input wire logic              arready,
   input wire logic [31:0]       rdata,
   input wire logic [1:0]        rresp,
   input wire logic              rvalid,
   input wire logic              rready,
   input wire logic              awvalid,
   input wire logic              awready,
   input wire logic              wvalid,
   input wire logic              wready,
   input wire logic [1:0]        bresp,
   input wire logic              bvalid,
   input wire logic              bready,
   // trigger
   input wire logic              adcTrigger
);
   import timer_pair_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic [ADDR_W-1:0] rdAddr_reg;
   // address of the read under way
   always_ff @(posedge mclk) begin
      if (arvalid && arready) rdAddr_reg <= araddr;
   end
   property p_rdAnswer;
      arvalid && arready |=> rvalid;
   endproperty
   a_rdAnswer: assert property (p_rdAnswer) else $error("read not answered");
   property p_rdHold;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_rdHold: assert property (p_rdHold) else $error("read answer dropped");
   property p_rdUpper;
      rvalid |-> rdata[31:16] == 16'h0000;
   endproperty
   a_rdUpper: assert property (p_rdUpper) else $error("upper read half not zero");
   property p_rdDone;
      rvalid && rready |=> !rvalid;
   endproperty
   a_rdDone: assert property (p_rdDone) else $error("read answered twice");
   property p_wrAnswer;
      awvalid && awready && wvalid && wready && !bvalid |-> ##[1:2] bvalid;
   endproperty
   a_wrAnswer: assert property (p_wrAnswer) else $error("write not answered");
   property p_wrHold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_wrHold: assert property (p_wrHold) else $error("write answer dropped");
   property p_trigPulse;
      adcTrigger |=> !adcTrigger;
   endproperty
   a_trigPulse: assert property (p_trigPulse) else $error("trigger too long");
   property p_ctrlZero;
      rvalid && rdAddr_reg == OFF_EVEN_CTRL |-> (rdata & ~{16'h0000, EVEN_CTRL_MASK}) == 0;
   endproperty
   a_ctrlZero: assert property (p_ctrlZero) else $error("unused bits read");
   property p_unmapped;
      arvalid && arready && araddr > 8'h1C |=> rresp == RESP_SLVERR && rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
endmodule

bind timer_pair timer_pair_props #(.ADDR_W(ADDR_W)) u_props (.mclk, .rst, .araddr,
   .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .awvalid, .awready, .wvalid,
   .wready, .bresp, .bvalid, .bready, .adcTrigger);

// >>> timer_pair_tb.sv
/*
 self-checking bench of the first timer pair over AXI4-Lite.
 assumes the design and its package; sources are driven in mclk.
*/
`timescale 1ns/1ps
module timer_pair_tb;
   import timer_pair_pkg::*;
   logic        mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, idleMode, adcTrigger;
   logic        evenIrq, oddIrq, evenGate, oddGate, evenExtPin;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, seed;
   logic [1:0]  bresp, rresp;
   logic [2:0]  evenPriority, oddPriority;
   logic [3:0]  srcs;
   logic [33:0] rdQ[$];
   logic [1:0]  bQ[$];
   int          gapQ[$];
   int          errCount = 0, comparisons = 0, gapCnt = 0;
   int          psDiv[4] = '{1, 8, 64, 256};
   logic [15:0] rstVal[8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hFFFF, 16'hFFFF, 16'h0, 16'h0};
   // sources: generic, low_power_rc_oscillator, odd pin, secondary
   timer_pair u_dut (.mclk, .rst, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
      .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .idleMode,
      .extGeneric(srcs[3]), .lprcOsc(srcs[2]), .secondaryOsc(srcs[0]), .evenExtPin,
      .oddExtPin(srcs[1]), .evenGate, .oddGate, .evenIrq, .oddIrq, .evenPriority,
      .oddPriority, .adcTrigger);
   // clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic note(input logic [33:0] e, input logic [33:0] g);
      comparisons++;
      if (g !== e) begin
         errCount++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic chkRead(input logic [33:0] e, input logic [33:0] g);
      note(e, g);
   endtask
   task automatic chkResp(input logic [1:0] e, input logic [1:0] g);
      note(34'(e), 34'(g));
   endtask
   task automatic chkGap(input int e, input int g);
      note(34'(e), 34'(g));
   endtask
   task automatic giveVerdict();
      if (errCount == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // one bus transfer; the expected answer is noted first
   task automatic bus(input bit isRd, input logic [7:0] a, input logic [15:0] d,
                      input logic [1:0] r = RESP_OKAY);
      logic [3:0] p, t;
      if (isRd) rdQ.push_back({r, 16'h0000, d});
      else bQ.push_back(r);
      p = isRd ? 4'b0011 : 4'b1101;
      @(posedge mclk);
      awaddr <= a;
      araddr <= a;
      wdata <= {16'h0000, d};
      {awvalid, wvalid, arvalid} <= p[3:1];
      {bready, rready} <= {!isRd, isRd};
      while (p != 4'h0) begin
         @(negedge mclk);
         t = p & {awready, wready, arready, isRd ? rvalid : bvalid};
         @(posedge mclk);
         p = p & ~t;
         {awvalid, wvalid, arvalid} <= p[3:1];
         if (t[0]) {bready, rready} <= 2'b00;
      end
   endtask
   // watcher: oldest note against each result
   always @(posedge mclk) begin
      if (rvalid && rready) chkRead(rdQ.pop_front(), {rresp, rdata});
      if (bvalid && bready) chkResp(bQ.pop_front(), bresp);
      if (adcTrigger && gapQ.size() > 0) chkGap(gapQ.pop_front(), gapCnt);
      gapCnt <= adcTrigger ? 1 : gapCnt + 1;
   end
   // watchdog
   initial begin
      #400000;
      errCount++;
      giveVerdict();
   end
   initial begin
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, idleMode, evenGate, oddGate} = '0;
      {evenExtPin, srcs, awaddr, araddr, wdata} = '0;
      seed = 32'h58;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      // reset values, unmapped places, unused control bits
      foreach (rstVal[i]) bus(1, 8'(i * 4), rstVal[i]);
      bus(1, 8'h20, 16'h0000, RESP_SLVERR);
      bus(0, 8'h22, 16'h1234, RESP_SLVERR);
      seed = xs(seed);
      bus(0, OFF_EVEN_CTRL, seed[15:0] & 16'h7FFF);
      bus(1, OFF_EVEN_CTRL, seed[15:0] & 16'h7FFF & EVEN_CTRL_MASK);
      bus(0, OFF_ODD_CTRL, seed[31:16] & 16'h7FFF);
      bus(1, OFF_ODD_CTRL, seed[31:16] & 16'h7FFF & ODD_CTRL_MASK);
      bus(0, OFF_EVEN_PER, seed[31:16]);
      bus(1, OFF_EVEN_PER, seed[31:16]);
      bus(0, OFF_EVEN_CTRL, 16'h0000);
      // every prescale code, odd timer alone, period zero
      bus(0, OFF_ODD_PER, 16'h0000);
      for (int c = 0; c < 4; c++) begin
         bus(0, OFF_ODD_CTRL, 16'h8000 | 16'(c << 4));
         do @(negedge mclk); while (!adcTrigger);
         @(negedge mclk);
         gapQ.push_back(2 * psDiv[c]);
         while (gapQ.size() > 0) @(negedge mclk);
      end
      // every extended source counts only its own input, gate ignored
      @(posedge mclk);
      idleMode <= 1'b1;
      bus(0, OFF_ODD_PER, 16'hFFFF);
      for (int c = 0; c < 4; c++) begin
         bus(0, OFF_ODD_CTRL, 16'h0000);
         bus(0, OFF_ODD_CNT, 16'h0000);
         bus(0, OFF_ODD_CTRL, 16'h8042 | 16'(c << 8));
         for (int j = 0; j < 5; j++) begin
            repeat (2) @(posedge mclk);
            srcs <= {j < 5, j < 4, j < 3, j < 2};
            repeat (2) @(posedge mclk);
            srcs <= 4'h0;
         end
         bus(0, OFF_ODD_CTRL, 16'h0000);
         bus(1, OFF_ODD_CNT, 16'(c + 2));
      end
      // idle stop halts the count
      bus(0, OFF_ODD_CNT, 16'h0007);
      bus(0, OFF_ODD_CTRL, 16'hA000);
      repeat (20) @(posedge mclk);
      bus(0, OFF_ODD_CTRL, 16'h0000);
      bus(1, OFF_ODD_CNT, 16'h0007);
      idleMode <= 1'b0;
      // gated accumulation on the even timer alone, flag on the gate fall
      bus(0, OFF_EVEN_PER, 16'hFFFF);
      bus(0, OFF_EVEN_CTRL, 16'h8040);
      evenGate <= 1'b1;
      repeat (20) @(posedge mclk);
      evenGate <= 1'b0;
      repeat (20) @(posedge mclk);
      bus(0, OFF_EVEN_CTRL, 16'h0000);
      bus(1, OFF_EVEN_CNT, 16'h000A);
      bus(1, OFF_FLAGS, 16'h0003);
      // joined pair carries into the odd word; odd settings ignored
      bus(0, OFF_ODD_CTRL, 16'h0030);
      bus(0, OFF_EVEN_CNT, 16'hFFFE);
      bus(0, OFF_ODD_CNT, 16'h0000);
      bus(0, OFF_EVEN_CTRL, 16'h8008);
      repeat (20) @(posedge mclk);
      bus(0, OFF_EVEN_CTRL, 16'h0008);
      repeat (20) @(posedge mclk);
      bus(1, OFF_ODD_CNT, 16'h0001);
      // joined match on both period words raises the odd flag
      bus(0, OFF_FLAGS, 16'h0003);
      bus(0, OFF_IRQ_CTRL, 16'h0523);
      bus(0, OFF_EVEN_PER, 16'h0000);
      bus(0, OFF_ODD_PER, 16'h0001);
      bus(0, OFF_EVEN_CNT, 16'hFFFC);
      bus(0, OFF_ODD_CNT, 16'h0000);
      bus(0, OFF_EVEN_CTRL, 16'h8008);
      repeat (20) @(posedge mclk);
      bus(0, OFF_EVEN_CTRL, 16'h0008);
      @(negedge mclk);
      note(34'hAA, {26'h0, oddIrq, evenIrq, oddPriority, evenPriority});
      bus(1, OFF_FLAGS, 16'h0002);
      bus(1, OFF_ODD_CNT, 16'h0000);
      @(posedge mclk);
      giveVerdict();
   end
endmodule
